// file: pkg/irq_status_pkg.sv
// What this block does
// - Fuse write done level sets bit 28
// - Bits 31:29 and 27 read zero, read-only
// - Transmit idle entry pulse sets bit 26
// - Transmit idle exit pulse sets bit 25
// - Receive idle entry pulse sets bit 24
// - Idle bits held zero while saving disabled
// - 8 ms reset watchdog timeout sets bit 23
// - Watchdog expiry releases MAC reset
// - RX FIFO overflow level sets bit 22
// - Transmit error level sets bit 21
// - USB event level sets bit 20
// - Transmit disabled level sets bit 19
// - Receive disabled level sets bit 18
// - Transceiver interrupt level sets bit 17
// - Data port done pulse sets bit 16
// - Identity register holds model code high
// - Identity register low half holds revision
// - MAC fault level sets bit 15
// - Pin event levels set bits 7:0; writing one to them pulses wake clear
package irq_status_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] IDENT_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] CTRL_OFS = 12'h010;
  localparam logic [11:0] WDOG_OFS = 12'h014;
  // Arbitrary neutral identity values
  localparam logic [15:0] MODEL_CODE = 16'hA5A5;
  localparam logic [15:0] REVISION_CODE = 16'h0001;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int FUSE_DONE_BIT = 28;
  localparam int TX_IDLE_ENTRY_BIT = 26;
  localparam int TX_IDLE_EXIT_BIT = 25;
  localparam int RX_IDLE_ENTRY_BIT = 24;
  localparam int MAC_RST_TO_BIT = 23;
  localparam int RX_OVF_BIT = 22;
  localparam int TX_ERR_BIT = 21;
  localparam int USB_EVT_BIT = 20;
  localparam int TX_DIS_BIT = 19;
  localparam int RX_DIS_BIT = 18;
  localparam int XCVR_BIT = 17;
  localparam int DP_DONE_BIT = 16;
  localparam int MAC_FAULT_BIT = 15;
  localparam int PIN_LO_BIT = 0;
  localparam int PIN_COUNT = 8;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;
  // Implemented write-clear bits; 27, 31:29 and 14:8 are absent
  localparam logic [31:0] STS_MASK = 32'h17FF_80FF;
  // Control register field
  localparam int CTRL_EEE_BIT = 0;
  // ----------------------------------------
  // Watchdog timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int WDOG_US = 8000;
  localparam int WDOG_CYCLES = (WDOG_US / 1000) * (CLK_HZ / 1000);
endpackage

// file: rtl/interrupt_status_and_id.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module interrupt_status_and_id #(
  parameter int WDOG_LIMIT = irq_status_pkg::WDOG_CYCLES,
  parameter logic [15:0] MODEL = irq_status_pkg::MODEL_CODE,
  parameter logic [15:0] REVISION = irq_status_pkg::REVISION_CODE
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Event sources
  input wire logic fuse_done_i,
  input wire logic tx_idle_entry_i,
  input wire logic tx_idle_exit_i,
  input wire logic rx_idle_entry_i,
  input wire logic rx_fifo_full_write_i,
  input wire logic tx_error_i,
  input wire logic usb_event_i,
  input wire logic tx_fifo_disabled_i,
  input wire logic mac_transmit_control_disabled_i,
  input wire logic rx_fifo_disabled_i,
  input wire logic mac_receive_control_disabled_i,
  input wire logic transceiver_irq_i,
  input wire logic dataport_done_i,
  input wire logic mac_fault_i,
  input wire logic [irq_status_pkg::PIN_COUNT-1:0] pin_event_i,
  // MAC reset watchdog
  input wire logic mac_rst_req_i,
  input wire logic mac_clk_ok_i,
  output logic mac_rst_o,
  // Side effects
  output logic rx_drop_o,
  output logic [irq_status_pkg::PIN_COUNT-1:0] pin_wake_clr_o,
  output logic energy_saving_enable_o
);
  import irq_status_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic eee;
    logic [PIN_COUNT-1:0] wake_clr;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  logic [31:0] sts;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] low_vec;
  logic wd_timeout;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  mac_reset_watchdog #(
    .LIMIT(WDOG_LIMIT)
  ) u_wdog (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .mac_rst_req_i(mac_rst_req_i),
    .mac_clk_ok_i(mac_clk_ok_i),
    .mac_rst_o(mac_rst_o),
    .timeout_o(wd_timeout)
  );

  // ----------------------------------------
  // Event mapping
  // ----------------------------------------
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[FUSE_DONE_BIT] = fuse_done_i;
    set_vec[TX_IDLE_ENTRY_BIT] = tx_idle_entry_i;
    set_vec[TX_IDLE_EXIT_BIT] = tx_idle_exit_i;
    set_vec[RX_IDLE_ENTRY_BIT] = rx_idle_entry_i;
    set_vec[MAC_RST_TO_BIT] = wd_timeout;
    set_vec[RX_OVF_BIT] = rx_fifo_full_write_i;
    set_vec[TX_ERR_BIT] = tx_error_i;
    set_vec[USB_EVT_BIT] = usb_event_i;
    set_vec[TX_DIS_BIT] = tx_fifo_disabled_i | mac_transmit_control_disabled_i;
    set_vec[RX_DIS_BIT] = rx_fifo_disabled_i | mac_receive_control_disabled_i;
    set_vec[XCVR_BIT] = transceiver_irq_i;
    set_vec[DP_DONE_BIT] = dataport_done_i;
    set_vec[MAC_FAULT_BIT] = mac_fault_i;
    set_vec[PIN_LO_BIT +: PIN_COUNT] = pin_event_i;
    set_vec = set_vec & STS_MASK;
    // Idle bits forced low while energy saving is off
    low_vec = 32'h0000_0000;
    low_vec[TX_IDLE_ENTRY_BIT] = ~st_ff.eee;
    low_vec[TX_IDLE_EXIT_BIT] = ~st_ff.eee;
    low_vec[RX_IDLE_ENTRY_BIT] = ~st_ff.eee;
    // Only ones written to implemented bits clear
    clr_vec = (reg_wr_i && hit(reg_addr_i, STATUS_OFS)) ? (reg_wdata_i & STS_MASK)
                                                      : 32'h0000_0000;
  end

  sticky_bits #(
    .W(32)
  ) u_sts (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .force_low_i(low_vec),
    .q_o(sts)
  );

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.wake_clr = clr_vec[PIN_LO_BIT +: PIN_COUNT];
    if (reg_wr_i && hit(reg_addr_i, CTRL_OFS)) begin
      nxt_st.eee = reg_wdata_i[CTRL_EEE_BIT];
    end
    if (reg_rd_i) begin
      if (hit(reg_addr_i, IDENT_OFS)) begin
        nxt_st.rdata = {MODEL, REVISION};
      end else if (hit(reg_addr_i, STATUS_OFS)) begin
        nxt_st.rdata = sts & STS_MASK;
      end else if (hit(reg_addr_i, CTRL_OFS)) begin
        nxt_st.rdata = {31'h0000_0000, st_ff.eee};
      end else if (hit(reg_addr_i, WDOG_OFS)) begin
        nxt_st.rdata = {31'h0000_0000, mac_rst_o};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign energy_saving_enable_o = st_ff.eee;
  assign pin_wake_clr_o = st_ff.wake_clr;
  // New data is dropped while the FIFO is full
  assign rx_drop_o = rx_fifo_full_write_i;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rd_sts;
    reg_rd_i && reg_addr_i == STATUS_OFS;
  endsequence

  property p_reserved;
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_rd_sts |=> (reg_rdata_o[31:29] == 3'h0 && !reg_rdata_o[27]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_idle_low;
    @(posedge mclk_i) disable iff (sys_rst_i)
    !st_ff.eee |=> (sts[26:24] == 3'h0);
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle bits set while disabled");

  property p_fuse;
    @(posedge mclk_i) disable iff (sys_rst_i)
    fuse_done_i |=> sts[FUSE_DONE_BIT];
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse bit not set");

  property p_tx_dis;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (tx_fifo_disabled_i || mac_transmit_control_disabled_i) |=> sts[TX_DIS_BIT];
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("tx disabled bit missing");

  property p_rx_dis;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (rx_fifo_disabled_i || mac_receive_control_disabled_i) |=> sts[RX_DIS_BIT];
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("rx disabled bit missing");

  property p_pulse_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (dataport_done_i ##1 (!clr_vec[DP_DONE_BIT])[*2]) |=> sts[DP_DONE_BIT];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("pulse bit lost");

  property p_clear;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (clr_vec[DP_DONE_BIT] && !dataport_done_i) |=> !sts[DP_DONE_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear");

  property p_zero_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == STATUS_OFS && !reg_wdata_i[TX_ERR_BIT] && sts[TX_ERR_BIT])
      |=> sts[TX_ERR_BIT];
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared bit");

  property p_id;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IDENT_OFS) |=> reg_rdata_o == {MODEL, REVISION};
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong");

  property p_wdog;
    @(posedge mclk_i) disable iff (sys_rst_i)
    wd_timeout |=> sts[MAC_RST_TO_BIT];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog bit not set");

  property p_fault;
    @(posedge mclk_i) disable iff (sys_rst_i)
    mac_fault_i |=> sts[MAC_FAULT_BIT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit not set");

  // ----------------------------------------
  // Per-source checks
  // ----------------------------------------
  sequence s_wr_sts;
    reg_wr_i && reg_addr_i == STATUS_OFS;
  endsequence

  property p_tx_idle_entry;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (tx_idle_entry_i && st_ff.eee) |=> sts[TX_IDLE_ENTRY_BIT];
  endproperty
  a_tx_idle_entry: assert property (p_tx_idle_entry) else $error("idle entry lost");

  property p_tx_idle_exit;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (tx_idle_exit_i && st_ff.eee) |=> sts[TX_IDLE_EXIT_BIT];
  endproperty
  a_tx_idle_exit: assert property (p_tx_idle_exit) else $error("idle exit lost");

  property p_rx_idle_entry;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (rx_idle_entry_i && st_ff.eee) |=> sts[RX_IDLE_ENTRY_BIT];
  endproperty
  a_rx_idle_entry: assert property (p_rx_idle_entry) else $error("rx idle lost");

  // A latched pulse must outlive its source while enabled and not cleared
  property p_idle_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (st_ff.eee && sts[TX_IDLE_ENTRY_BIT] && !clr_vec[TX_IDLE_ENTRY_BIT])
      |=> sts[TX_IDLE_ENTRY_BIT];
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle bit dropped");

  property p_rx_ovf;
    @(posedge mclk_i) disable iff (sys_rst_i)
    rx_fifo_full_write_i |=> sts[RX_OVF_BIT];
  endproperty
  a_rx_ovf: assert property (p_rx_ovf) else $error("overflow bit not set");

  property p_tx_err;
    @(posedge mclk_i) disable iff (sys_rst_i)
    tx_error_i |=> sts[TX_ERR_BIT];
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("tx error bit not set");

  property p_usb;
    @(posedge mclk_i) disable iff (sys_rst_i)
    usb_event_i |=> sts[USB_EVT_BIT];
  endproperty
  a_usb: assert property (p_usb) else $error("usb bit not set");

  // Level sources re-assert, so a clear while still active must not stick
  property p_usb_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (clr_vec[USB_EVT_BIT] && usb_event_i) |=> sts[USB_EVT_BIT];
  endproperty
  a_usb_hold: assert property (p_usb_hold) else $error("usb bit dropped");

  property p_xcvr;
    @(posedge mclk_i) disable iff (sys_rst_i)
    transceiver_irq_i |=> sts[XCVR_BIT];
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver bit not set");

  property p_xcvr_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (clr_vec[XCVR_BIT] && transceiver_irq_i) |=> sts[XCVR_BIT];
  endproperty
  a_xcvr_hold: assert property (p_xcvr_hold) else $error("transceiver bit dropped");

  property p_fuse_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (clr_vec[FUSE_DONE_BIT] && fuse_done_i) |=> sts[FUSE_DONE_BIT];
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse bit dropped");

  property p_fault_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (clr_vec[MAC_FAULT_BIT] && mac_fault_i) |=> sts[MAC_FAULT_BIT];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault bit dropped");

  // Catches a pulse bit that rises with no source behind it
  property p_dp_quiet;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (!sts[DP_DONE_BIT] && !dataport_done_i) |=> !sts[DP_DONE_BIT];
  endproperty
  a_dp_quiet: assert property (p_dp_quiet) else $error("data port bit spurious");

  property p_reserved_state;
    @(posedge mclk_i) disable iff (sys_rst_i)
    sts[31:29] == 3'h0 && !sts[27];
  endproperty
  a_reserved_state: assert property (p_reserved_state) else $error("reserved bit set");

  property p_wd_clean;
    @(posedge mclk_i) disable iff (sys_rst_i)
    (mac_rst_o && mac_clk_ok_i && !mac_rst_req_i) |=> (!mac_rst_o && !wd_timeout);
  endproperty
  a_wd_clean: assert property (p_wd_clean) else $error("release with clocks failed");

  property p_wake_idle;
    @(posedge mclk_i) disable iff (sys_rst_i)
    !reg_wr_i |=> (pin_wake_clr_o == '0);
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("wake clear without write");

  for (genvar k = 0; k < PIN_COUNT; k++) begin : g_pin
    property p_pin_set;
      @(posedge mclk_i) disable iff (sys_rst_i)
      pin_event_i[k] |=> sts[PIN_LO_BIT + k];
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin bit not set");

    property p_wake;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wdata_i[PIN_LO_BIT + k] ##0 s_wr_sts) |=> pin_wake_clr_o[k];
    endproperty
    a_wake: assert property (p_wake) else $error("wake clear missing");
  end
endmodule

// file: rtl/mac_reset_watchdog.sv
`timescale 1ns/100ps
module mac_reset_watchdog #(
  parameter int LIMIT = irq_status_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // MAC reset request and clock presence
  input wire logic mac_rst_req_i,
  input wire logic mac_clk_ok_i,
  // Results
  output logic mac_rst_o,
  output logic timeout_o
);
  import irq_status_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic rst;
    logic to;
  } wd_state_t;

  wd_state_t st_ff;
  wd_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.to = 1'b0;
    if (mac_rst_req_i) begin
      nxt_st.rst = 1'b1;
      nxt_st.cnt = 32'h0000_0000;
    end else if (st_ff.rst) begin
      if (mac_clk_ok_i) begin
        nxt_st.rst = 1'b0;
      end else if (st_ff.cnt == 32'(LIMIT - 1)) begin
        // Release anyway so the MAC is not stuck waiting on a dead PHY
        nxt_st.rst = 1'b0;
        nxt_st.to = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mac_rst_o = st_ff.rst;
  assign timeout_o = st_ff.to;

  property p_release;
    @(posedge mclk_i) disable iff (sys_rst_i)
    timeout_o |-> !mac_rst_o;
  endproperty
  a_release: assert property (p_release) else $error("reset held after timeout");

  property p_timeout_pulse;
    @(posedge mclk_i) disable iff (sys_rst_i)
    timeout_o |=> !timeout_o;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout not a pulse");
endmodule

// file: rtl/sticky_bits.sv
`timescale 1ns/100ps
module sticky_bits #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Events and clears
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  input wire logic [W-1:0] force_low_i,
  // State
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] q;
  } sb_state_t;

  sb_state_t st_ff;
  sb_state_t nxt_st;

  // Set wins over a clear in the same cycle
  always_comb begin
    nxt_st.q = ((st_ff.q & ~clr_i) | set_i) & ~force_low_i;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.q;
endmodule

// file: sim/interrupt_status_and_id_tb.sv
`timescale 1ns/100ps
module interrupt_status_and_id_tb;
  import irq_status_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Short watchdog so the timeout case stays cheap
  localparam int LIM = 20;
  logic mclk_i;
  logic sys_rst_i;
  logic [11:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [17:0] lv;
  logic [3:0] pv;
  logic mac_rst_req_i;
  logic mac_clk_ok_i;
  logic mac_rst_o;
  logic rx_drop_o;
  logic [7:0] pin_wake_clr_o;
  logic energy_saving_enable_o;
  logic [31:0] exp_s, exp_rd, clr, nx, d;
  logic en_m, rd_pend, wk_any;
  logic [7:0] wk_must;
  int fails, tests_run, n, r;
  interrupt_status_and_id #(.WDOG_LIMIT(LIM)) i_interrupt_status_and_id (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fuse_done_i(lv[0]), .tx_idle_entry_i(pv[0]),
    .tx_idle_exit_i(pv[1]), .rx_idle_entry_i(pv[2]), .rx_fifo_full_write_i(lv[1]),
    .tx_error_i(lv[2]), .usb_event_i(lv[3]), .tx_fifo_disabled_i(lv[4]),
    .mac_transmit_control_disabled_i(lv[5]), .rx_fifo_disabled_i(lv[6]), .mac_receive_control_disabled_i(lv[7]),
    .transceiver_irq_i(lv[8]), .dataport_done_i(pv[3]), .mac_fault_i(lv[9]),
    .pin_event_i(lv[17:10]), .mac_rst_req_i(mac_rst_req_i), .mac_clk_ok_i(mac_clk_ok_i),
    .mac_rst_o(mac_rst_o), .rx_drop_o(rx_drop_o), .pin_wake_clr_o(pin_wake_clr_o),
    .energy_saving_enable_o(energy_saving_enable_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] setv(input logic [17:0] l, input logic [3:0] p, input logic en);
    logic [31:0] s;
    s = 32'h0;
    s[28] = l[0];
    s[22] = l[1];
    s[21] = l[2];
    s[20] = l[3];
    s[19] = l[4] | l[5];
    s[18] = l[6] | l[7];
    s[17] = l[8];
    s[15] = l[9];
    s[7:0] = l[17:10];
    s[26:24] = en ? {p[0], p[1], p[2]} : 3'h0;
    s[16] = p[3];
    return s;
  endfunction
  // Status model; the watchdog bit is judged by the directed case only
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      exp_s <= 32'h0;
      en_m <= 1'b0;
      rd_pend <= 1'b0;
      wk_any <= 1'b0;
    end else begin
      clr = (reg_wr_i && reg_addr_i == 12'h00C) ? reg_wdata_i : 32'h0;
      nx = (exp_s & ~clr) | setv(lv, pv, en_m);
      if (!en_m) nx[26:24] = 3'h0;
      exp_s <= nx;
      if (reg_wr_i && reg_addr_i == 12'h010) en_m <= reg_wdata_i[0];
      rd_pend <= reg_rd_i && reg_addr_i == 12'h00C;
      exp_rd <= exp_s;
      wk_any <= |clr[7:0];
      wk_must <= clr[7:0] & exp_s[7:0] & ~lv[17:10];
      if (rd_pend) check("status", reg_rdata_o & 32'hFF7F_FFFF, exp_rd & 32'hFF7F_FFFF);
      check("drop", {31'h0, rx_drop_o}, {31'h0, lv[1]});
      if (wk_any) check("wake", {24'h0, pin_wake_clr_o & wk_must}, {24'h0, wk_must});
      else check("wake idle", {24'h0, pin_wake_clr_o}, 32'h0);
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    v = reg_rdata_o;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk_i);
    pv[k] <= 1'b1;
    @(posedge mclk_i);
    pv[k] <= 1'b0;
  endtask
  task automatic rst_wait();
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
  endtask
  initial begin
    #2500000;
    fails++;
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reg_addr_i = 12'h000;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    lv = 18'h0;
    pv = 4'h0;
    mac_rst_req_i = 1'b0;
    mac_clk_ok_i = 1'b0;
    fails = 0;
    tests_run = 0;
    r = $urandom(32'h5DFD);
    rst_wait();
    rd(12'h00C, d);
    check("status reset", d, 32'h0);
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, d);
    check("id", d, {MODEL_CODE, REVISION_CODE});
    wr(12'h008, 32'hFFFF_FFFF);
    rd(12'h008, d);
    check("unmapped", d, 32'h0);
    check("mac reset idle", {31'h0, mac_rst_o}, 32'h0);
    // Each level: clear while high must not stick, clear after drop must
    for (int k = 0; k < 18; k++) begin
      @(posedge mclk_i);
      lv[k] <= 1'b1;
      wr(12'h00C, 32'hFFFF_FFFF);
      rd(12'h00C, d);
      @(posedge mclk_i);
      lv[k] <= 1'b0;
      rd(12'h00C, d);
      wr(12'h00C, 32'hFFFF_FFFF);
      rd(12'h00C, d);
    end
    // Idle pulses ignored while energy saving is off, sticky once on
    for (int k = 0; k < 4; k++) pulse(k);
    rd(12'h00C, d);
    wr(12'h010, 32'h0000_0001);
    rd(12'h010, d);
    check("ctrl", d, 32'h1);
    check("enable out", {31'h0, energy_saving_enable_o}, 32'h1);
    for (int k = 0; k < 4; k++) pulse(k);
    rd(12'h00C, d);
    wr(12'h00C, 32'h0);
    rd(12'h00C, d);
    wr(12'h00C, 32'h0500_0000);
    rd(12'h00C, d);
    wr(12'h010, 32'h0);
    rd(12'h00C, d);
    check("idle held low", d & 32'h0700_0000, 32'h0);
    wr(12'h010, 32'h0000_0001);
    // Watchdog expiry without clocks
    @(posedge mclk_i);
    mac_rst_req_i <= 1'b1;
    @(posedge mclk_i);
    mac_rst_req_i <= 1'b0;
    @(negedge mclk_i);
    check("mac reset held", {31'h0, mac_rst_o}, 32'h1);
    // Two cycles of the hold go to this read, so the count starts at 2
    rd(12'h014, d);
    check("reset readback", d, 32'h1);
    n = 2;
    while (mac_rst_o === 1'b1 && n < 3 * LIM) begin
      @(posedge mclk_i);
      n++;
    end
    check("watchdog span", {31'h0, n >= LIM - 2 && n <= LIM + 2}, 32'h1);
    repeat (2) @(posedge mclk_i);
    rd(12'h00C, d);
    check("timeout flag", {31'h0, d[23]}, 32'h1);
    wr(12'h00C, 32'h0080_0000);
    rd(12'h00C, d);
    check("timeout cleared", {31'h0, d[23]}, 32'h0);
    // Clocks present: reset released with no flag
    @(posedge mclk_i);
    mac_clk_ok_i <= 1'b1;
    mac_rst_req_i <= 1'b1;
    @(posedge mclk_i);
    mac_rst_req_i <= 1'b0;
    repeat (LIM + 4) @(posedge mclk_i);
    rd(12'h00C, d);
    check("no timeout", {30'h0, d[23], mac_rst_o}, 32'h0);
    // Random traffic with the model judging every status read
    for (int i = 0; i < 600; i++) begin
      @(posedge mclk_i);
      r = $urandom % 6;
      lv <= 18'($urandom) & 18'($urandom) & 18'($urandom);
      pv <= 4'($urandom) & 4'($urandom);
      reg_wr_i <= (r == 0);
      reg_rd_i <= (r == 1 || r == 2);
      reg_addr_i <= ($urandom % 8 == 0) ? 12'h008 : 12'h00C;
      reg_wdata_i <= $urandom;
    end
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    lv <= 18'h0;
    pv <= 4'h0;
    // Reset in mid-run clears everything latched
    rst_wait();
    rd(12'h00C, d);
    check("status after reset", d, 32'h0);
    rd(12'h010, d);
    check("ctrl after reset", d, 32'h0);
    conclude();
  end
endmodule
